// ---- rsg_reset_strap.sv ----
// Reset halt sequencing, strap capture and GPIO 6..8 alternate function mux
`timescale 1ns/1ps
//
// Contract
// - Fundamental reset holds all internal logic reset; here straps, mode decode and synchronisers keep running during it
// - Halt during reset keeps quasi-reset, SMBus active
// - Clearing halt bit starts normal operation
// - Codes 0..3 select single partition modes
// - Codes 4..7 reserved, no defined mode
// - Codes 8, 9 select reduced latency modes
// - Code C selects multi-partition unattached I2C EEPROM
// - Codes D, F select multi-partition disabled modes
// - Frequency select 0 means 100, 1 means 125 MHz
// - Failover input change with enable raises event
// - Pin 6 is failover 1 or failover 3
// - Pin 7 is failover 2 or link-up output
// - Pin 8 is expander irq or link-active output
// - Pins 6..8 also usable as plain GPIO
// - One strap per lane stack picks its configuration
// - Two-bit clock mode strap picks port clocking
module rsg_reset_strap (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Reset pins
  input wire logic fundamental_reset_n,
  input wire logic reset_halt_request,
  // Halt bit clear from the SMBus register path
  input wire logic halt_bit_clear,
  // Straps
  input wire logic [3:0] switch_operating_mode_strap,
  input wire logic global_clock_freq_select,
  input wire logic [1:0] port_clocking_mode_strap,
  input wire logic stack0_config_strap,
  input wire logic stack1_config_strap,
  input wire logic stack2_config_strap,
  input wire logic stack3_config_strap,
  // GPIO control and pins, index 0..2 for pins 6..8
  input wire rsg_pkg::rsg_gpio_ctl_t [2:0] gpio_ctl,
  input wire logic [2:0] gpio_pin_in,
  output logic [2:0] gpio_pin_out,
  output logic [2:0] gpio_pin_oe,
  // Port 8 status and failover enables
  input wire logic port8_link_up,
  input wire logic port8_link_active,
  input wire logic [2:0] failover_enable,
  // Status outputs
  output logic core_reset,
  output logic smbus_enable,
  output logic halt_bit,
  output rsg_pkg::rsg_straps_t straps,
  output rsg_pkg::rsg_mode_t switch_mode,
  output logic mode_reserved,
  output logic [7:0] gclk_freq_mhz,
  output logic [2:0] failover_event,
  output logic [2:0] failover_level,
  output logic io_expander_irq,
  output logic [2:0] gpio_in_val
);
  import rsg_pkg::*;

  typedef enum logic [1:0] {RSG_ST_RESET, RSG_ST_HALT, RSG_ST_RUN} rsg_state_t;

  logic [1:0] perst_sync_reg;
  logic [1:0] halt_sync_reg;
  logic [2:0] gpio_meta_reg;
  logic [2:0] gpio_sync_reg;
  logic [10:0] strap_meta_reg;
  logic [10:0] strap_sync_reg;
  logic perst_n;
  rsg_state_t state_reg;
  rsg_state_t state_next;
  logic [2:0] fo_raw;
  logic [2:0] fo_prev_reg;
  logic fo_valid_reg;

  // Two-flop synchronisers for every pin input
  always_ff @(posedge core_clk) begin
    if (rst) begin
      perst_sync_reg <= 2'h0;
      halt_sync_reg <= 2'h0;
      gpio_meta_reg <= 3'h0;
      gpio_sync_reg <= 3'h0;
      strap_meta_reg <= 11'h000;
      strap_sync_reg <= 11'h000;
    end else begin
      perst_sync_reg <= {perst_sync_reg[0], fundamental_reset_n};
      halt_sync_reg <= {halt_sync_reg[0], reset_halt_request};
      gpio_meta_reg <= gpio_pin_in;
      gpio_sync_reg <= gpio_meta_reg;
      strap_meta_reg <= {switch_operating_mode_strap, global_clock_freq_select,
        port_clocking_mode_strap, stack3_config_strap, stack2_config_strap,
        stack1_config_strap, stack0_config_strap};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  assign perst_n = perst_sync_reg[1];

  // Sequencer: reset, optional halt, then run
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      RSG_ST_RESET: begin
        if (perst_n) begin
          state_next = halt_sync_reg[1] ? RSG_ST_HALT : RSG_ST_RUN;
        end
      end
      RSG_ST_HALT: begin
        if (halt_bit_clear) begin
          state_next = RSG_ST_RUN;
        end
      end
      RSG_ST_RUN: begin
        state_next = RSG_ST_RUN;
      end
    endcase
    if (!perst_n) begin
      state_next = RSG_ST_RESET;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= RSG_ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Reset and halt outputs registered from next state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      core_reset <= 1'b1;
      smbus_enable <= 1'b0;
      halt_bit <= 1'b0;
    end else begin
      core_reset <= (state_next != RSG_ST_RUN);
      smbus_enable <= (state_next != RSG_ST_RESET);
      halt_bit <= (state_next == RSG_ST_HALT);
    end
  end

  // Straps follow the pins only while reset is held, so the value seen at
  // release is what stays; the board must not move them afterwards
  always_ff @(posedge core_clk) begin
    if (rst) begin
      straps <= RSG_STRAPS_RST;
    end else if (state_reg == RSG_ST_RESET && !perst_n) begin
      straps <= rsg_straps_t'(strap_sync_reg);
    end
  end

  // Mode decode
  always_ff @(posedge core_clk) begin
    if (rst) begin
      switch_mode <= RSG_MODE_RESERVED;
      mode_reserved <= 1'b1;
      gclk_freq_mhz <= 8'(RSG_GCLK_SEL0_MHZ);
    end else begin
      mode_reserved <= 1'b0;
      unique case (straps.sw_mode)
        RSG_SW_SINGLE: switch_mode <= RSG_MODE_SINGLE;
        RSG_SW_SINGLE_EE: switch_mode <= RSG_MODE_SINGLE_EE;
        RSG_SW_JUMP0: switch_mode <= RSG_MODE_SINGLE_JUMP0;
        RSG_SW_JUMP1: switch_mode <= RSG_MODE_SINGLE_JUMP1;
        RSG_SW_LOWLAT: switch_mode <= RSG_MODE_SINGLE_LOWLAT;
        RSG_SW_EE_LOWLAT: switch_mode <= RSG_MODE_SINGLE_EE_LOWLAT;
        RSG_SW_MULTI_UNATT_EE: switch_mode <= RSG_MODE_MULTI_UNATT_I2C_EE;
        RSG_SW_MULTI_DIS: switch_mode <= RSG_MODE_MULTI_DISABLED;
        RSG_SW_MULTI_DIS_EE: switch_mode <= RSG_MODE_MULTI_DISABLED_EE;
        default: begin
          switch_mode <= RSG_MODE_RESERVED;
          mode_reserved <= 1'b1;
        end
      endcase
      gclk_freq_mhz <= straps.gclk_fsel ? 8'(RSG_GCLK_SEL1_MHZ)
                                        : 8'(RSG_GCLK_SEL0_MHZ);
    end
  end

  // Failover inputs: 1 on pin 6 alt1, 2 on pin 7 alt1, 3 on pin 6 alt2
  always_comb begin
    fo_raw[0] = (gpio_ctl[0].fsel == RSG_FN_ALT1) & gpio_sync_reg[0];
    fo_raw[1] = (gpio_ctl[1].fsel == RSG_FN_ALT1) & gpio_sync_reg[1];
    fo_raw[2] = (gpio_ctl[0].fsel == RSG_FN_ALT2) & gpio_sync_reg[0];
  end

  // Change detect; the first compare after leaving reset is skipped so
  // the sampled reset value is not taken for a change
  always_ff @(posedge core_clk) begin
    if (rst || core_reset) begin
      fo_prev_reg <= 3'h0;
      fo_valid_reg <= 1'b0;
      failover_event <= 3'h0;
      failover_level <= 3'h0;
    end else begin
      fo_prev_reg <= fo_raw;
      fo_valid_reg <= 1'b1;
      failover_level <= fo_raw;
      failover_event <= fo_valid_reg ? ((fo_raw ^ fo_prev_reg) & failover_enable)
                                     : 3'h0;
    end
  end

  // Pin drivers and input observation
  generate
    for (genvar i = 0; i < RSG_NUM_GPIO; i++) begin : g_pin
      always_ff @(posedge core_clk) begin
        if (rst || core_reset) begin
          gpio_pin_out[i] <= 1'b0;
          gpio_pin_oe[i] <= 1'b0;
          gpio_in_val[i] <= 1'b0;
        end else begin
          gpio_in_val[i] <= gpio_sync_reg[i];
          if (gpio_ctl[i].fsel == RSG_FN_GPIO) begin
            gpio_pin_out[i] <= gpio_ctl[i].out_val;
            gpio_pin_oe[i] <= gpio_ctl[i].out_en;
          end else if (gpio_ctl[i].fsel == RSG_FN_ALT2 && i == 1) begin
            gpio_pin_out[i] <= ~port8_link_up;
            gpio_pin_oe[i] <= 1'b1;
          end else if (gpio_ctl[i].fsel == RSG_FN_ALT2 && i == 2) begin
            gpio_pin_out[i] <= ~port8_link_active;
            gpio_pin_oe[i] <= 1'b1;
          end else begin
            gpio_pin_out[i] <= 1'b0;
            gpio_pin_oe[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Expander interrupt, active low on pin 8 first alternate function
  always_ff @(posedge core_clk) begin
    if (rst || core_reset) begin
      io_expander_irq <= 1'b0;
    end else begin
      io_expander_irq <= (gpio_ctl[2].fsel == RSG_FN_ALT1) & ~gpio_sync_reg[2];
    end
  end

  // Assertions
  reset_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    !perst_n |=> core_reset) else $error("core left reset while reset pin low");
  halt_enter_a: assert property (@(posedge core_clk) disable iff (rst)
    state_reg == RSG_ST_RESET && perst_n && halt_sync_reg[1]
      |=> halt_bit && core_reset && smbus_enable) else $error("halt not entered");
  halt_exit_a: assert property (@(posedge core_clk) disable iff (rst)
    state_reg == RSG_ST_HALT && halt_bit_clear && perst_n
      |=> !core_reset && !halt_bit) else $error("halt clear did not release");
  halt_stay_a: assert property (@(posedge core_clk) disable iff (rst)
    halt_bit && !halt_bit_clear |=> core_reset) else $error("left halt early");
  mode_res_a: assert property (@(posedge core_clk) disable iff (rst)
    straps.sw_mode inside {[4'h4:4'h7]} |=> mode_reserved)
    else $error("reserved code decoded");
  mode_single_a: assert property (@(posedge core_clk) disable iff (rst)
    straps.sw_mode == RSG_SW_SINGLE |=> switch_mode == RSG_MODE_SINGLE && !mode_reserved)
    else $error("code 0 misdecoded");
  mode_jump1_a: assert property (@(posedge core_clk) disable iff (rst)
    straps.sw_mode == RSG_SW_JUMP1 |=> switch_mode == RSG_MODE_SINGLE_JUMP1)
    else $error("code 3 misdecoded");
  mode_lowlat_a: assert property (@(posedge core_clk) disable iff (rst)
    straps.sw_mode == 4'h8 |=> switch_mode == RSG_MODE_SINGLE_LOWLAT)
    else $error("code 8 misdecoded");
  mode_ee_lowlat_a: assert property (@(posedge core_clk) disable iff (rst)
    straps.sw_mode == RSG_SW_EE_LOWLAT |=> switch_mode == RSG_MODE_SINGLE_EE_LOWLAT)
    else $error("code 9 misdecoded");
  mode_multi_a: assert property (@(posedge core_clk) disable iff (rst)
    straps.sw_mode == RSG_SW_MULTI_UNATT_EE |=> switch_mode == RSG_MODE_MULTI_UNATT_I2C_EE)
    else $error("code c misdecoded");
  mode_dis_a: assert property (@(posedge core_clk) disable iff (rst)
    straps.sw_mode == RSG_SW_MULTI_DIS |=> switch_mode == RSG_MODE_MULTI_DISABLED)
    else $error("code d misdecoded");
  mode_dis_ee_a: assert property (@(posedge core_clk) disable iff (rst)
    straps.sw_mode == RSG_SW_MULTI_DIS_EE |=> switch_mode == RSG_MODE_MULTI_DISABLED_EE)
    else $error("code f misdecoded");
  gclk_freq_a: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> gclk_freq_mhz == ($past(straps.gclk_fsel) ? 8'h7d : 8'h64))
    else $error("clock frequency misdecoded");
  strap_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    !core_reset && $past(!core_reset) |-> $stable(straps))
    else $error("straps moved while running");
  fo_event_a: assert property (@(posedge core_clk) disable iff (rst || core_reset)
    failover_event[0] |-> $past(failover_enable[0]))
    else $error("failover event without enable");
  fo_change_a: assert property (@(posedge core_clk) disable iff (rst || core_reset)
    fo_valid_reg |=> failover_event ==
      ((failover_level ^ $past(failover_level)) & $past(failover_enable)))
    else $error("failover event does not follow input change");
  pin6_alt2_a: assert property (@(posedge core_clk) disable iff (rst || core_reset)
    gpio_ctl[0].fsel == RSG_FN_ALT2 |=> !gpio_pin_oe[0] &&
      failover_level[2] == $past(gpio_sync_reg[0])) else $error("pin 6 failover 3 wrong");
  link_up_a: assert property (@(posedge core_clk) disable iff (rst || core_reset)
    gpio_ctl[1].fsel == RSG_FN_ALT2 |=> gpio_pin_oe[1] && gpio_pin_out[1] ==
      !$past(port8_link_up)) else $error("link-up pin wrong");
  link_active_a: assert property (@(posedge core_clk) disable iff (rst || core_reset)
    gpio_ctl[2].fsel == RSG_FN_ALT2 |=> gpio_pin_oe[2] && gpio_pin_out[2] ==
      !$past(port8_link_active)) else $error("link-active pin wrong");
  expander_irq_a: assert property (@(posedge core_clk) disable iff (rst || core_reset)
    gpio_ctl[2].fsel == RSG_FN_ALT1 |=> !gpio_pin_oe[2] &&
      io_expander_irq == !$past(gpio_sync_reg[2])) else $error("expander irq wrong");
  plain_gpio_a: assert property (@(posedge core_clk) disable iff (rst || core_reset)
    gpio_ctl[1].fsel == RSG_FN_GPIO |=> gpio_pin_oe[1] == $past(gpio_ctl[1].out_en) &&
      gpio_pin_out[1] == $past(gpio_ctl[1].out_val)) else $error("plain gpio pin 7 wrong");
endmodule

// ---- rsg_pkg.sv ----
// Package for the reset, strap capture and GPIO alternate-function block
package rsg_pkg;
  // Operating modes decoded from the switch mode strap
  typedef enum logic [3:0] {
    RSG_MODE_SINGLE,
    RSG_MODE_SINGLE_EE,
    RSG_MODE_SINGLE_JUMP0,
    RSG_MODE_SINGLE_JUMP1,
    RSG_MODE_SINGLE_LOWLAT,
    RSG_MODE_SINGLE_EE_LOWLAT,
    RSG_MODE_MULTI_UNATT_I2C_EE,
    RSG_MODE_MULTI_DISABLED,
    RSG_MODE_MULTI_DISABLED_EE,
    RSG_MODE_RESERVED
  } rsg_mode_t;

  // Strap codes
  localparam logic [3:0] RSG_SW_SINGLE = 4'h0;
  localparam logic [3:0] RSG_SW_SINGLE_EE = 4'h1;
  localparam logic [3:0] RSG_SW_JUMP0 = 4'h2;
  localparam logic [3:0] RSG_SW_JUMP1 = 4'h3;
  localparam logic [3:0] RSG_SW_LOWLAT = 4'h8;
  localparam logic [3:0] RSG_SW_EE_LOWLAT = 4'h9;
  localparam logic [3:0] RSG_SW_MULTI_UNATT_EE = 4'hc;
  localparam logic [3:0] RSG_SW_MULTI_DIS = 4'hd;
  localparam logic [3:0] RSG_SW_MULTI_DIS_EE = 4'hf;

  // Reference clock frequencies in MHz
  localparam int RSG_GCLK_SEL0_MHZ = 100;
  localparam int RSG_GCLK_SEL1_MHZ = 125;

  // GPIO pin function selections
  localparam logic [1:0] RSG_FN_GPIO = 2'h0;
  localparam logic [1:0] RSG_FN_ALT1 = 2'h1;
  localparam logic [1:0] RSG_FN_ALT2 = 2'h2;

  localparam int RSG_NUM_GPIO = 3;
  localparam int RSG_NUM_STACK = 4;
  localparam int RSG_NUM_FAILOVER = 3;

  // Captured strap set
  typedef struct packed {
    logic [3:0] sw_mode;
    logic gclk_fsel;
    logic [1:0] clk_mode;
    logic [3:0] stack_cfg;
  } rsg_straps_t;

  localparam rsg_straps_t RSG_STRAPS_RST = '0;

  // Per-pin GPIO control: function select, output value, output enable
  typedef struct packed {
    logic [1:0] fsel;
    logic out_val;
    logic out_en;
  } rsg_gpio_ctl_t;
endpackage

// ---- rsg_board_model.sv ----
// Board model: strap pins, fundamental reset source, halt-bit clear
`timescale 1ns/1ps
module rsg_board_model (
  // Clock
  input wire logic core_clk,
  // Reset source and SMBus halt clear
  output logic fundamental_reset_n,
  output logic reset_halt_request,
  output logic halt_bit_clear,
  // Strap pins, packed as the captured strap set
  output logic [10:0] strap_pins
);
  initial begin
    fundamental_reset_n = 1'b0;
    reset_halt_request = 1'b0;
    halt_bit_clear = 1'b0;
    strap_pins = 11'h000;
  end
  // Straps move only while reset is low, so capture never sees a change
  task automatic pulse_reset(input logic [10:0] s, input logic halt);
    @(posedge core_clk);
    fundamental_reset_n <= 1'b0;
    strap_pins <= s;
    reset_halt_request <= halt;
    repeat (8) @(posedge core_clk);
    fundamental_reset_n <= 1'b1;
  endtask
  task automatic clear_halt();
    @(posedge core_clk);
    halt_bit_clear <= 1'b1;
    @(posedge core_clk);
    halt_bit_clear <= 1'b0;
  endtask
endmodule

// ---- rsg_reset_strap_bench.sv ----
// Testbench for the reset, strap and GPIO alternate-function block
`timescale 1ns/1ps
module rsg_reset_strap_bench;
  import rsg_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic fundamental_reset_n, reset_halt_request, halt_bit_clear;
  logic [10:0] strap_pins;
  rsg_gpio_ctl_t [2:0] gpio_ctl = '0;
  logic [2:0] pin_drv = 3'h0;
  logic [2:0] failover_enable = 3'h0;
  logic port8_link_up = 1'b0;
  logic port8_link_active = 1'b0;
  logic [2:0] pin_lvl, gpio_pin_out, gpio_pin_oe, failover_event, failover_level, gpio_in_val;
  logic core_reset, smbus_enable, halt_bit, mode_reserved, io_expander_irq;
  rsg_straps_t straps;
  rsg_mode_t switch_mode;
  logic [7:0] gclk_freq_mhz;
  int failures = 0;
  int compares = 0;
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  // The block wins the wire while it drives, otherwise the board level shows
  assign pin_lvl = (gpio_pin_oe & gpio_pin_out) | (~gpio_pin_oe & pin_drv);
  rsg_board_model u_rsg_board_model (.core_clk(core_clk),
    .fundamental_reset_n(fundamental_reset_n), .reset_halt_request(reset_halt_request),
    .halt_bit_clear(halt_bit_clear), .strap_pins(strap_pins));
  rsg_reset_strap u_rsg_reset_strap (.core_clk(core_clk), .rst(rst),
    .fundamental_reset_n(fundamental_reset_n), .reset_halt_request(reset_halt_request),
    .halt_bit_clear(halt_bit_clear), .switch_operating_mode_strap(strap_pins[10:7]),
    .global_clock_freq_select(strap_pins[6]), .port_clocking_mode_strap(strap_pins[5:4]),
    .stack0_config_strap(strap_pins[0]), .stack1_config_strap(strap_pins[1]),
    .stack2_config_strap(strap_pins[2]), .stack3_config_strap(strap_pins[3]),
    .gpio_ctl(gpio_ctl), .gpio_pin_in(pin_lvl), .gpio_pin_out(gpio_pin_out),
    .gpio_pin_oe(gpio_pin_oe), .port8_link_up(port8_link_up),
    .port8_link_active(port8_link_active), .failover_enable(failover_enable),
    .core_reset(core_reset), .smbus_enable(smbus_enable), .halt_bit(halt_bit),
    .straps(straps), .switch_mode(switch_mode), .mode_reserved(mode_reserved),
    .gclk_freq_mhz(gclk_freq_mhz), .failover_event(failover_event),
    .failover_level(failover_level), .io_expander_irq(io_expander_irq),
    .gpio_in_val(gpio_in_val));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wcyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  function automatic rsg_mode_t exp_mode(input logic [3:0] c);
    case (c)
      RSG_SW_SINGLE: return RSG_MODE_SINGLE;
      RSG_SW_SINGLE_EE: return RSG_MODE_SINGLE_EE;
      RSG_SW_JUMP0: return RSG_MODE_SINGLE_JUMP0;
      RSG_SW_JUMP1: return RSG_MODE_SINGLE_JUMP1;
      RSG_SW_LOWLAT: return RSG_MODE_SINGLE_LOWLAT;
      RSG_SW_EE_LOWLAT: return RSG_MODE_SINGLE_EE_LOWLAT;
      RSG_SW_MULTI_UNATT_EE: return RSG_MODE_MULTI_UNATT_I2C_EE;
      RSG_SW_MULTI_DIS: return RSG_MODE_MULTI_DISABLED;
      RSG_SW_MULTI_DIS_EE: return RSG_MODE_MULTI_DISABLED_EE;
      default: return RSG_MODE_RESERVED;
    endcase
  endfunction
  // Reset with the given straps and wait until run or halt is reached
  task automatic boot(input logic [10:0] s, input logic halt);
    int n;
    fork
      u_rsg_board_model.pulse_reset(s, halt);
      begin
        wcyc(6);
        chk({core_reset, smbus_enable}, 16'h2);
      end
    join
    for (n = 0; n < 30; n++) begin
      @(negedge core_clk);
      if (halt ? (halt_bit === 1'b1) : (core_reset === 1'b0)) break;
    end
    if (n == 30) begin
      failures++;
      finish_test();
    end
  endtask
  task automatic test_modes();
    logic [10:0] s;
    for (int c = 0; c < 16; c++) begin
      s = {c[3:0], c[0], c[2:1], ~c[3:0]};
      boot(s, 1'b0);
      wcyc(2);
      chk(switch_mode, exp_mode(c[3:0]));
      chk(mode_reserved, 16'(exp_mode(c[3:0]) == RSG_MODE_RESERVED));
      chk(gclk_freq_mhz, 16'(c[0] ? RSG_GCLK_SEL1_MHZ : RSG_GCLK_SEL0_MHZ));
      chk(straps, s);
    end
    $display("test_modes done");
  endtask
  task automatic test_halt();
    boot(11'h000, 1'b1);
    wcyc(10);
    chk({core_reset, smbus_enable, halt_bit}, 16'h7);
    u_rsg_board_model.clear_halt();
    wcyc(1);
    chk({core_reset, smbus_enable, halt_bit}, 16'h2);
    $display("test_halt done");
  endtask
  // Raise one pin under one function and collect failover pulses
  task automatic fo_try(input int p, input logic [1:0] fs, input int b, input logic en);
    logic [2:0] seen;
    seen = 3'h0;
    @(posedge core_clk);
    gpio_ctl[p] <= {fs, 2'b00};
    failover_enable <= en ? 3'(1 << b) : 3'h0;
    wcyc(4);
    @(posedge core_clk);
    pin_drv[p] <= 1'b1;
    repeat (8) begin
      @(negedge core_clk);
      seen |= failover_event;
    end
    chk(seen, en ? 16'(1 << b) : 16'h0);
    chk(failover_level, 16'(1 << b));
    @(posedge core_clk);
    pin_drv[p] <= 1'b0;
    wcyc(8);
    @(posedge core_clk);
    gpio_ctl[p] <= 4'h0;
  endtask
  task automatic test_pins();
    @(posedge core_clk);
    gpio_ctl[2] <= {RSG_FN_ALT1, 2'b00};
    wcyc(6);
    chk(io_expander_irq, 16'h1);
    @(posedge core_clk);
    pin_drv[2] <= 1'b1;
    wcyc(6);
    chk(io_expander_irq, 16'h0);
    @(posedge core_clk);
    gpio_ctl[1] <= {RSG_FN_ALT2, 2'b00};
    gpio_ctl[2] <= {RSG_FN_ALT2, 2'b00};
    port8_link_up <= 1'b1;
    wcyc(4);
    chk({gpio_pin_oe[2:1], gpio_pin_out[2:1]}, 16'he);
    @(posedge core_clk);
    port8_link_up <= 1'b0;
    port8_link_active <= 1'b1;
    wcyc(4);
    chk({gpio_pin_oe[2:1], gpio_pin_out[2:1]}, 16'hd);
    @(posedge core_clk);
    gpio_ctl <= {4'h3, 4'h1, 4'h3};
    wcyc(4);
    chk({gpio_pin_oe, gpio_pin_out}, 16'h3d);
    @(posedge core_clk);
    gpio_ctl <= '0;
    pin_drv <= 3'h2;
    wcyc(6);
    chk({gpio_pin_oe, gpio_in_val}, 16'h2);
    $display("test_pins done");
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    test_modes();
    test_halt();
    fo_try(0, RSG_FN_ALT1, 0, 1'b1);
    fo_try(0, RSG_FN_ALT2, 2, 1'b1);
    fo_try(1, RSG_FN_ALT1, 1, 1'b1);
    fo_try(0, RSG_FN_ALT1, 0, 1'b0);
    $display("test_failover done");
    test_pins();
    finish_test();
  end
endmodule
